//--- verilog/tgc_timer.sv
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// R1 - Clock select low: 8-bit counter steps once per instruction cycle.
// R2 - Own 8-bit prescaler, not shared with any watchdog.
// R3 - Count write blocks counting for the two following cycles.
// R4 - Clock select high: count on external clock pin edges.
// R5 - Edge select picks rising or falling transition as counting edge.
// R6 - Wrap FFh to 00h makes a pulse usable as second timer gate.
// R7 - External gate pin is a selectable gate source.
// R8 - Toggle mode: flip-flop changes on every gate incrementing edge.
// R9 - Toggle flip-flop held at zero while toggle mode is off.
// R10 - Software avoids toggle enable together with polarity change.
// R11 - Arm after single-pulse enable; enable timer on next gate edge.
// R12 - Hardware clears arm bit at trailing edge of captured pulse.
// R13 - After pulse, gate ignored until arm bit set again.
// R14 - Software clears arm bit when leaving single-pulse mode.
// R15 - Toggle plus single-pulse together measure one full gate cycle.
// R16 - Present gate control level readable as status bit.
// R17 - Gate level status valid even with gating disabled.
// R18 - Falling gate level sets gate event flag, even if gating off.
// R19 - Counter wrap sets sticky overflow flag until software clears.
module tgc_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        t0_ext_clock_pin,
	input  wire logic        t1_gate_pin,
	output var  logic        t1_count_enable,
	output var  logic        t0_overflow_pulse,
	output var  logic        irq
);

	logic [5:0]  ctrl_q;
	logic [6:0]  gate_q;
	logic [7:0]  count_q;
	logic [1:0]  status_q;
	logic [1:0]  mask_q;
	logic [7:0]  ps_cnt_q;
	logic [1:0]  hold_q;
	logic        clk_pin_s;
	logic        gate_pin_s;
	logic        src_prev_q;
	logic        ovf_q;
	logic        gsrc_prev_q;
	logic        tog_q;
	logic        level_prev_q;
	logic        wr_acc;
	logic        rd_acc;
	logic        wr_count;
	logic        wr_gate;
	logic        src_lvl;
	logic        src_edge;
	logic        ps_tick;
	logic [7:0]  ps_lim;
	logic        addr_hit;
	logic        tick;
	logic        wrap;
	logic        gsrc_raw;
	logic        gsrc_pol;
	logic        gate_edge;
	logic        gate_level;
	logic        gate_fall;
	logic [1:0]  ev;
	tgc_pkg::tgc_gate_cfg_t gcfg;
	tgc_pkg::tgc_sp_state_t sp_q;

	// Pin synchronisers
	tgc_sync u_sync_clk (
		.clk   (pclk),
		.rst_n (presetn),
		.din   (t0_ext_clock_pin),
		.dout  (clk_pin_s)
	);

	tgc_sync u_sync_gate (
		.clk   (pclk),
		.rst_n (presetn),
		.din   (t1_gate_pin),
		.dout  (gate_pin_s)
	);

	// APB decode; zero wait state
	assign wr_acc   = psel && penable && pwrite;
	assign rd_acc   = psel && !penable && !pwrite;
	assign wr_count = wr_acc && (paddr == tgc_pkg::OFF_COUNT);
	assign wr_gate  = wr_acc && (paddr == tgc_pkg::OFF_GATE);

	// Mapped register window
	assign addr_hit = (paddr == tgc_pkg::OFF_CTRL) ||
		(paddr == tgc_pkg::OFF_COUNT) || (paddr == tgc_pkg::OFF_GATE) ||
		(paddr == tgc_pkg::OFF_STATUS) || (paddr == tgc_pkg::OFF_MASK);

	// Named view of the gate control bits
	assign gcfg = '{en:     gate_q[tgc_pkg::GATE_EN],
	                pol:    gate_q[tgc_pkg::GATE_POL],
	                toggle: gate_q[tgc_pkg::GATE_TOGGLE],
	                spm:    gate_q[tgc_pkg::GATE_SPM],
	                src:    gate_q[tgc_pkg::GATE_SRC]};

	// Counter clock source and edge choice
	assign src_lvl  = ctrl_q[tgc_pkg::CTRL_CS] ? clk_pin_s : 1'b1; // R4
	// Falling edge counts when edge select set
	assign src_edge = ctrl_q[tgc_pkg::CTRL_CS] ?
		(ctrl_q[tgc_pkg::CTRL_EDGE] ? (src_prev_q && !src_lvl)
		                            : (!src_prev_q && src_lvl)) // R5
		: 1'b1; // R1

	// Prescaler: divide by 2^(ps+1) unless bypassed
	// Terminal count is a mask of ps+1 ones
	assign ps_lim  = 8'hFF >> (3'h7 - ctrl_q[2:0]);
	assign ps_tick = ctrl_q[tgc_pkg::CTRL_PSA] ? src_edge :
		(src_edge && (ps_cnt_q == ps_lim)); // R2
	assign tick = ps_tick && (hold_q == 2'h0) && !wr_count; // R3
	assign wrap = tick && (count_q == 8'hFF);

	// Edge detect history for pin clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev_q <= 1'b0;
		end else begin
			src_prev_q <= src_lvl;
		end
	end

	// Prescaler counter, own to this timer
	// Phase restarts on a count write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_cnt_q <= 8'h00;
		end else if (wr_count) begin
			ps_cnt_q <= 8'h00;
		end else if (src_edge) begin
			if (ps_cnt_q == ps_lim) begin
				ps_cnt_q <= 8'h00;
			end else begin
				ps_cnt_q <= ps_cnt_q + 8'h01; // R2
			end
		end
	end

	// Write hold-off counter
	// A count write wins over a tick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= 2'h0;
		end else if (wr_count) begin
			hold_q <= tgc_pkg::WR_HOLD; // R3
		end else if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end

	// Main 8-bit counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= tgc_pkg::COUNT_RST;
		end else if (wr_count) begin
			count_q <= pwdata[7:0];
		end else if (tick) begin
			count_q <= count_q + 8'h01; // R1
		end
	end

	// Overflow pulse to gate logic and pin
	// Registered so the pin sees a clean one-cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= wrap; // R6
		end
	end
	assign t0_overflow_pulse = ovf_q;

	// Gate source select and polarity
	assign gsrc_raw = gcfg.src ? ovf_q : gate_pin_s; // R6 R7
	assign gsrc_pol = gcfg.pol ? gsrc_raw : !gsrc_raw;
	assign gate_edge = gsrc_pol && !gsrc_prev_q;

	// Gate source history, reset to its idle level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gsrc_prev_q <= 1'b1;
		end else begin
			gsrc_prev_q <= gsrc_pol;
		end
	end

	// Toggle flip-flop
	// Held clear while off so the measured edge is known
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_q <= 1'b0;
		end else if (!gcfg.toggle) begin
			tog_q <= 1'b0; // R9
		end else if (gate_edge) begin
			tog_q <= !tog_q; // R8
		end
	end

	// Level after toggle stage; toggle path combines with single pulse
	assign gate_level = gcfg.toggle ? tog_q : gsrc_pol; // R8 R15
	assign gate_fall  = level_prev_q && !gate_level;

	// Gate level history, reset to its idle level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_prev_q <= 1'b1;
		end else begin
			level_prev_q <= gate_level;
		end
	end

	// Single-pulse sequencer and arm bit
	// Dropping mode or arm returns to idle at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_q <= tgc_pkg::SP_IDLE;
		end else if (!gcfg.spm || !gate_q[tgc_pkg::GATE_ARM]) begin
			sp_q <= tgc_pkg::SP_IDLE; // R13
		end else begin
			case (sp_q)
				tgc_pkg::SP_IDLE: begin
					sp_q <= tgc_pkg::SP_WAIT; // R11
				end
				tgc_pkg::SP_WAIT: begin
					if (gate_level && !level_prev_q) begin
						sp_q <= tgc_pkg::SP_RUN; // R11
					end
				end
				tgc_pkg::SP_RUN: begin
					if (gate_fall) begin
						sp_q <= tgc_pkg::SP_IDLE; // R12
					end
				end
				default: begin
					sp_q <= tgc_pkg::SP_IDLE;
				end
			endcase
		end
	end

	// Control register and gate register writes
	// A software write to arm wins over the hardware clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= tgc_pkg::CTRL_RST;
			gate_q <= tgc_pkg::GATE_RST;
		end else begin
			if (wr_acc && (paddr == tgc_pkg::OFF_CTRL)) begin
				ctrl_q <= pwdata[5:0];
			end
			if (wr_gate) begin
				gate_q <= {pwdata[6], gate_level, pwdata[4:0]};
			end else begin
				gate_q[tgc_pkg::GATE_LEVEL] <= gate_level; // R16 R17
				if (gcfg.spm && sp_q == tgc_pkg::SP_RUN && gate_fall) begin
					gate_q[tgc_pkg::GATE_ARM] <= 1'b0; // R12
				end
			end
		end
	end

	// Second timer count enable
	// Gating off leaves the second timer free to count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t1_count_enable <= 1'b0;
		end else if (!gcfg.en) begin
			t1_count_enable <= 1'b1;
		end else if (gcfg.spm) begin
			t1_count_enable <= (sp_q == tgc_pkg::SP_RUN) && gate_level; // R13
		end else begin
			t1_count_enable <= gate_level;
		end
	end

	// Sticky events: set wins over write-one clear
	assign ev = {gate_fall, wrap}; // R18 R19
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= tgc_pkg::EV_RST;
			mask_q   <= tgc_pkg::EV_RST;
		end else begin
			if (wr_acc && (paddr == tgc_pkg::OFF_STATUS)) begin
				status_q <= (status_q & ~pwdata[1:0]) | ev; // R19
			end else begin
				status_q <= status_q | ev; // R18
			end
			if (wr_acc && (paddr == tgc_pkg::OFF_MASK)) begin
				mask_q <= pwdata[1:0];
			end
		end
	end

	// Interrupt level
	// One cycle behind the status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end

	// Read data captured in setup, returned in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_hit;
			if (rd_acc) begin
				case (paddr)
					tgc_pkg::OFF_CTRL:   prdata <= {26'h0, ctrl_q};
					tgc_pkg::OFF_COUNT:  prdata <= {24'h0, count_q};
					tgc_pkg::OFF_GATE:   prdata <= {25'h0, gate_q}; // R16
					tgc_pkg::OFF_STATUS: prdata <= {30'h0, status_q};
					tgc_pkg::OFF_MASK:   prdata <= {30'h0, mask_q};
					default:             prdata <= 32'h0000_0000;
				endcase
			end else if (!psel) begin
				prdata <= 32'h0000_0000;
			end
		end
	end

endmodule : tgc_timer

`default_nettype wire

//--- verilog/tgc_pkg.sv
package tgc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_COUNT   = 8'h04;
	localparam logic [7:0] OFF_GATE    = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0C;
	localparam logic [7:0] OFF_MASK    = 8'h10;

	// Control register fields
	localparam int CTRL_PS_LSB   = 0;   // Prescaler rate, 3 bits
	localparam int CTRL_PSA      = 3;   // 1 = prescaler bypassed
	localparam int CTRL_EDGE     = 4;   // t0_edge_select
	localparam int CTRL_CS       = 5;   // t0_clock_select

	// Gate control register fields
	localparam int GATE_EN       = 0;   // t1_gate_enable
	localparam int GATE_POL      = 1;   // Gate active high when set
	localparam int GATE_TOGGLE   = 2;   // gate_toggle_enable
	localparam int GATE_SPM      = 3;   // gate_single_pulse_enable
	localparam int GATE_ARM      = 4;   // gate_pulse_arm
	localparam int GATE_LEVEL    = 5;   // gate_level_status, read only
	localparam int GATE_SRC      = 6;   // 0 = pin, 1 = counter overflow

	// Status and mask bits
	localparam int ST_OVF        = 0;   // Counter overflow
	localparam int ST_GATE       = 1;   // gate_event_flag

	// Reset values
	localparam logic [5:0] CTRL_RST  = 6'h08;
	localparam logic [6:0] GATE_RST  = 7'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [1:0] EV_RST    = 2'h0;

	// Cycles of count suppression after a count write
	localparam logic [1:0] WR_HOLD   = 2'h2;

	// Gate path configuration bundle
	typedef struct packed {
		logic en;
		logic pol;
		logic toggle;
		logic spm;
		logic src;
	} tgc_gate_cfg_t;

	// Single-pulse sequencer states
	typedef enum logic [2:0] {
		SP_IDLE = 3'b001,
		SP_WAIT = 3'b010,
		SP_RUN  = 3'b100
	} tgc_sp_state_t;

endpackage : tgc_pkg

//--- verilog/tgc_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for a pin level
module tgc_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic din,
	output var  logic dout
);

	logic meta_q;

	// First stage read only by second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

endmodule : tgc_sync

`default_nettype wire

//--- verification/tgc_pins.sv
`timescale 1ns/1ns
`default_nettype none

// Count clock and gate pins of the outside world
module tgc_pins (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	input  wire logic gate,
	output var  logic ext_clk,
	output var  logic gate_pin
);
	logic ph_q;

	// Count clock flips every second cycle, stands still when idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_q    <= 1'b0;
			ext_clk <= 1'b0;
		end else if (run) begin
			ph_q <= ~ph_q;
			if (ph_q) begin
				ext_clk <= ~ext_clk;
			end
		end else begin
			ph_q <= 1'b0;
		end
	end

	// Gate pin follows the requested level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_pin <= 1'b0;
		end else begin
			gate_pin <= gate;
		end
	end
endmodule : tgc_pins

`default_nettype wire

//--- verification/tgc_timer_checker.sv
`timescale 1ns/1ns
`default_nettype none

// Port-level checks of the timer block
module tgc_timer_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        t0_ext_clock_pin,
	input wire logic        t1_gate_pin,
	input wire logic        t1_count_enable,
	input wire logic        t0_overflow_pulse,
	input wire logic        irq
);
	logic [5:0] ctrl_q;
	logic [1:0] mask_q;
	logic       gen_q;
	logic       wr;
	logic       wr_cnt;

	// Accepted writes at the access edge
	assign wr     = psel && penable && pwrite && pready && !pslverr;
	assign wr_cnt = wr && paddr == tgc_pkg::OFF_COUNT;

	// Shadow copies of the bits the checks depend on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= tgc_pkg::CTRL_RST;
			mask_q <= 2'h0;
			gen_q  <= 1'b0;
		end else if (wr) begin
			if (paddr == tgc_pkg::OFF_CTRL) ctrl_q <= pwdata[5:0];
			if (paddr == tgc_pkg::OFF_MASK) mask_q <= pwdata[1:0];
			if (paddr == tgc_pkg::OFF_GATE) gen_q <= pwdata[0];
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("No answer after setup");
	property p_acc;
		pready |-> psel && penable;
	endproperty
	a_acc: assert property (p_acc) else $error("Answer outside access");
	property p_err;
		pslverr |-> pready && (pwrite || prdata == 32'h0);
	endproperty
	a_err: assert property (p_err) else $error("Bad error answer");
	property p_ovf;
		$rose(t0_overflow_pulse) |=> !t0_overflow_pulse;
	endproperty
	a_ovf: assert property (p_ovf) else $error("Wrap pulse too long");
	property p_hold;
		wr_cnt |=> ##1 !t0_overflow_pulse [*2];
	endproperty
	a_hold: assert property (p_hold) else $error("Count not held");
	property p_wrap;
		wr_cnt && pwdata[7:0] == 8'hFF && !ctrl_q[5] && ctrl_q[3]
			|-> ##[3:5] t0_overflow_pulse;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Wrap missing");
	property p_irq;
		t0_overflow_pulse && mask_q[0] |-> ##[1:3] irq;
	endproperty
	a_irq: assert property (p_irq) else $error("No interrupt");
	property p_irqm;
		irq |-> (mask_q | $past(mask_q)) != 2'h0;
	endproperty
	a_irqm: assert property (p_irqm) else $error("Masked interrupt");
	property p_tce;
		$past(presetn, 2) && !gen_q && !$past(gen_q) && !$past(gen_q, 2)
			|-> t1_count_enable;
	endproperty
	a_tce: assert property (p_tce) else $error("Ungated timer stopped");

	c_ovf: cover property (t0_overflow_pulse);
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
endmodule : tgc_timer_checker

bind tgc_timer tgc_timer_checker chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.t0_ext_clock_pin(t0_ext_clock_pin), .t1_gate_pin(t1_gate_pin),
	.t1_count_enable(t1_count_enable),
	.t0_overflow_pulse(t0_overflow_pulse), .irq(irq)
);

`default_nettype wire

//--- verification/test_tgc_timer.sv
`timescale 1ns/1ns
`default_nettype none

// Self-checking bench of the timer and gate block
module test_tgc_timer;
	logic        pclk, presetn, psel, penable, pwrite, run, gate;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, t0_clk, t1_gate, tce, ovf, irq;
	int          n_fail, n_compared;

	tgc_timer dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .t0_ext_clock_pin(t0_clk),
		.t1_gate_pin(t1_gate), .t1_count_enable(tce),
		.t0_overflow_pulse(ovf), .irq(irq)
	);
	tgc_pins pins (
		.pclk(pclk), .presetn(presetn), .run(run), .gate(gate),
		.ext_clk(t0_clk), .gate_pin(t1_gate)
	);

	// Clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			n_fail++;
		end
	endtask : chk

	// One bus transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		chk("pready", 32'h1, {31'h0, pready});
		r = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, r);
	endtask : rd

	// Gate level then settle
	task automatic gt(input logic v);
		gate <= v;
		repeat (8) @(posedge pclk);
	endtask : gt

	// Reset values and an unmapped place
	task automatic t_reset;
		rd(tgc_pkg::OFF_CTRL, {26'h0, tgc_pkg::CTRL_RST}, "ctrl");
		rd(tgc_pkg::OFF_MASK, 32'h0, "mask");
		rd(8'h14, 32'h0, "unmapped");
		chk("slverr", 32'h1, {31'h0, pslverr});
	endtask : t_reset

	// Count hold after write, wrap and interrupt
	task automatic t_timer;
		int k;
		apb(1'b1, tgc_pkg::OFF_COUNT, 32'h10);
		rd(tgc_pkg::OFF_COUNT, 32'h10, "count held");
		rd(tgc_pkg::OFF_COUNT, 32'h12, "count runs");
		apb(1'b1, tgc_pkg::OFF_MASK, 32'h1);
		apb(1'b1, tgc_pkg::OFF_COUNT, 32'hFF);
		k = 0;
		while (irq !== 1'b1 && k < 10) begin
			@(posedge pclk);
			k++;
		end
		chk("irq set", 32'h1, {31'h0, irq});
		apb(1'b0, tgc_pkg::OFF_STATUS, 32'h0);
		chk("ovf flag", 32'h1, r & 32'h1);
		apb(1'b1, tgc_pkg::OFF_STATUS, 32'h1);
		repeat (3) @(posedge pclk);
		chk("irq clear", 32'h0, {31'h0, irq});
		apb(1'b1, tgc_pkg::OFF_MASK, 32'h0);
	endtask : t_timer

	// Prescaled timer: divide by four after the write hold
	task automatic t_pre;
		apb(1'b1, tgc_pkg::OFF_CTRL, 32'h1);
		apb(1'b1, tgc_pkg::OFF_COUNT, 32'h0);
		repeat (19) @(posedge pclk);
		rd(tgc_pkg::OFF_COUNT, 32'h5, "prescaled");
		apb(1'b1, tgc_pkg::OFF_CTRL, 32'h8);
	endtask : t_pre

	// Pin counting on rising then falling edges
	task automatic t_ext;
		for (int e = 0; e < 2; e++) begin
			apb(1'b1, tgc_pkg::OFF_CTRL, 32'h28 | (e << 4));
			apb(1'b1, tgc_pkg::OFF_COUNT, 32'h0);
			run <= 1'b1;
			repeat (14) @(posedge pclk);
			run <= 1'b0;
			repeat (6) @(posedge pclk);
			rd(tgc_pkg::OFF_COUNT, 32'h4, "pin count");
		end
		apb(1'b1, tgc_pkg::OFF_CTRL, 32'h8);
	endtask : t_ext

	// Gate level, event flag, toggle and single pulse
	task automatic t_gate;
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h2);
		gt(1'b1);
		rd(tgc_pkg::OFF_GATE, 32'h22, "level");
		apb(1'b1, tgc_pkg::OFF_STATUS, 32'h2);
		apb(1'b0, tgc_pkg::OFF_STATUS, 32'h0);
		chk("gate flag clr", 32'h0, r & 32'h2);
		gt(1'b0);
		apb(1'b0, tgc_pkg::OFF_STATUS, 32'h0);
		chk("gate flag", 32'h2, r & 32'h2);
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h3);
		repeat (2) @(posedge pclk);
		chk("gated off", 32'h0, {31'h0, tce});
		gt(1'b1);
		chk("gated on", 32'h1, {31'h0, tce});
		gt(1'b0);
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h7);
		gt(1'b1);
		gt(1'b0);
		chk("toggle hi", 32'h1, {31'h0, tce});
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h3);
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h7);
		repeat (3) @(posedge pclk);
		chk("toggle clr", 32'h0, {31'h0, tce});
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h0B);
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h1B);
		gt(1'b1);
		chk("pulse on", 32'h1, {31'h0, tce});
		gt(1'b0);
		rd(tgc_pkg::OFF_GATE, 32'h0B, "arm clear");
		gt(1'b1);
		chk("pulse done", 32'h0, {31'h0, tce});
		gt(1'b0);
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h0F);
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h1F);
		gt(1'b1);
		gt(1'b0);
		chk("cycle on", 32'h1, {31'h0, tce});
		gt(1'b1);
		gt(1'b0);
		rd(tgc_pkg::OFF_GATE, 32'h0F, "cycle end");
		apb(1'b1, tgc_pkg::OFF_GATE, 32'h3);
	endtask : t_gate

	// Counts and verdict
	task automatic final_report;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// Main sequence
	initial begin
		n_fail = 0;
		n_compared = 0;
		{presetn, psel, penable, pwrite, run, gate} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_timer;
		t_pre;
		t_ext;
		t_gate;
		final_report;
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		final_report;
	end
endmodule : test_tgc_timer

`default_nettype wire
